//--- sdm_params.svh
// timing counts, mode-word fields and command address bits for the module link
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH
`define SDM_CLK_NS      50
`define SDM_REF_MS      64
`define SDM_REF_ROWS    4096
`define SDM_REF_CYC     ((`SDM_REF_MS * 1000000 / `SDM_REF_ROWS) / `SDM_CLK_NS)
`define SDM_RAS_MIN_NS  50
`define SDM_RAS_MAX_NS  16000
`define SDM_RAS_MIN_CYC ((`SDM_RAS_MIN_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_RAS_MAX_CYC (`SDM_RAS_MAX_NS / `SDM_CLK_NS)
`define SDM_RC_CYC      10
`define SDM_RCD_CYC     3
`define SDM_RP_CYC      3
`define SDM_RRD_CYC     2
`define SDM_MRD_CYC     2
`define SDM_RDL_CYC     2
`define SDM_INIT_REFS   2
`define SDM_MR_BL_LSB   0
`define SDM_MR_BT_BIT   3
`define SDM_MR_LAT_LSB  4
`define SDM_ALL_BANKS   10
`define SDM_LAT_RST     3'h3
`define SDM_BL_RST      3'h0
`endif

//--- sdm_pkg.sv
// command codes, host states and burst length decode for the module link
package sdm_pkg;
	// {row strobe, column strobe, write strobe}, all active low
	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdm_cmd_e;

	typedef enum logic [6:0] {
		S_INIT_PRE = 7'h01,
		S_INIT_REF = 7'h02,
		S_MODE     = 7'h04,
		S_IDLE     = 7'h08,
		S_RW       = 7'h10,
		S_PRE      = 7'h20,
		S_WAIT     = 7'h40
	} sdm_state_e;

	function automatic logic [3:0] bl_of(input logic [2:0] code);
		bl_of = (code > 3'h3) ? 4'h8 : (4'h1 << code[1:0]);
	endfunction : bl_of
endpackage : sdm_pkg

//--- sdm_link_if.sv
// command, address, mask and shared data lines between controller and module
`timescale 1ns/1ps
interface sdm_link_if;
	logic                chip_select_low_rank_n;
	sdm_pkg::sdm_cmd_e   cmd;
	logic [1:0]          bank_select;
	logic [11:0]         addr;
	logic [7:0]          byte_mask;
	logic [63:0]         dq_h_o;
	logic                dq_h_oe;
	logic [63:0]         dq_d_o;
	logic [7:0]          dq_d_oe;
	logic [63:0]         dq;

	// per lane: module drive wins, then controller, else floats low
	for (genvar i = 0; i < 8; i++) begin : g_lane
		assign dq[8*i +: 8] = dq_d_oe[i] ? dq_d_o[8*i +: 8] :
			(dq_h_oe ? dq_h_o[8*i +: 8] : 8'h00);
	end

	modport host (output chip_select_low_rank_n, cmd, bank_select, addr, byte_mask,
		dq_h_o, dq_h_oe, input dq);
	modport dev (input chip_select_low_rank_n, cmd, bank_select, addr, byte_mask, dq,
		output dq_d_o, dq_d_oe);
endinterface : sdm_link_if

//--- sdm_fifo.sv
// read-data fifo with registered head word
`timescale 1ns/1ps
module sdm_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input  wire logic                         mclk,
	input  wire logic                         nrst,
	input  wire logic                         in_valid,
	output logic                              in_ready,
	input  wire logic [WIDTH-1:0]             in_data,
	output logic                              out_valid,
	input  wire logic                         out_ready,
	output logic [WIDTH-1:0]                  out_data,
	output logic [$clog2(DEPTH)+1:0]          level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign push     = in_valid & in_ready;
	assign pop      = (cnt_q != '0) & (~out_valid | out_ready);
	assign level    = (AW+2)'(cnt_q) + (AW+2)'(out_valid);

	always_ff @(posedge mclk) begin
		if (push)
			mem[wr_q] <= in_data;
		if (pop)
			out_data <= mem[rd_q];
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			if (pop)
				out_valid <= 1'b1;
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule : sdm_fifo

//--- sdm_dev_end.sv
// memory module end: registered command decode, four banks, bursts, latency
`timescale 1ns/1ps
`include "sdm_params.svh"
module sdm_dev_end #(
	parameter int ROW_W = 2,
	parameter int COL_W = 8
) (
	input  wire logic  mclk,
	input  wire logic  nrst,
	sdm_link_if.dev    lnk,
	output logic [3:0] bank_open,
	output logic [2:0] read_latency_cycles
);
	localparam int AW = 2 + ROW_W + COL_W;
	logic [63:0] mem [2**AW];

	logic              cs_n_q;
	sdm_pkg::sdm_cmd_e cmd_q;
	logic [1:0]        ba_q;
	logic [11:0]       a_q;
	logic [7:0]        dqm_q;
	logic [63:0]       dq_q;
	logic [11:0]       row_q [4];
	logic [2:0]        blc_q;
	logic              bt_q;
	logic              bst_on_q;
	logic              bst_wr_q;
	logic [1:0]        bst_bank_q;
	logic [COL_W-1:0]  bst_base_q;
	logic [3:0]        bst_idx_q;
	logic [3:0]        bst_len_q;
	logic [1:0]        rp_v_q;
	logic [63:0]       rp_d_q [2];
	logic [7:0]        mask_p1_q;
	logic [63:0]       dq_o_q;
	logic [7:0]        oe_q;
	logic              hit;
	logic              new_rw;
	logic              beat_on;
	logic              beat_wr;
	logic [1:0]        beat_bank;
	logic [COL_W-1:0]  beat_col;
	logic [AW-1:0]     beat_idx;
	logic              out_v;

	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
		input logic [3:0] idx, input logic [3:0] len, input logic il);
		logic [COL_W-1:0] m;
		m = COL_W'(len - 4'h1);
		if (il)
			burst_col = (base & ~m) | ((base ^ COL_W'(idx)) & m);
		else
			burst_col = (base & ~m) | ((base + COL_W'(idx)) & m);
	endfunction : burst_col

	// every pin is taken on the rising edge, no other buffering
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cs_n_q <= 1'b1;
			cmd_q  <= sdm_pkg::CMD_NOP;
			ba_q   <= 2'h0;
			a_q    <= 12'h000;
			dqm_q  <= 8'hFF;
			dq_q   <= 64'h0;
		end else begin
			cs_n_q <= lnk.chip_select_low_rank_n; // [RL1]
			cmd_q  <= lnk.cmd; // [RL1]
			ba_q   <= lnk.bank_select; // [RL1]
			a_q    <= lnk.addr; // [RL1]
			dqm_q  <= lnk.byte_mask; // [RL1]
			dq_q   <= lnk.dq; // [RL1]
		end
	end

	assign hit    = ~cs_n_q; // [RL16]
	assign new_rw = hit & bank_open[ba_q] & ((cmd_q == sdm_pkg::CMD_RD) |
		(cmd_q == sdm_pkg::CMD_WR));

	// a new column command preempts the running burst every cycle
	always_comb begin
		if (new_rw) begin // [RL2]
			beat_on   = 1'b1;
			beat_wr   = cmd_q == sdm_pkg::CMD_WR;
			beat_bank = ba_q; // [RL16]
			beat_col  = a_q[COL_W-1:0];
		end else begin
			beat_on   = bst_on_q;
			beat_wr   = bst_wr_q;
			beat_bank = bst_bank_q;
			beat_col  = burst_col(bst_base_q, bst_idx_q, bst_len_q, bt_q); // [RL7]
		end
	end
	assign beat_idx = {beat_bank, row_q[beat_bank][ROW_W-1:0], beat_col};

	// independent row state per bank
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bank_open <= 4'h0;
			for (int b = 0; b < 4; b++)
				row_q[b] <= 12'h000;
		end else if (hit && cmd_q == sdm_pkg::CMD_ACT) begin
			bank_open[ba_q] <= 1'b1; // [RL3]
			row_q[ba_q]     <= a_q; // [RL3]
		end else if (hit && cmd_q == sdm_pkg::CMD_PRE) begin
			if (a_q[`SDM_ALL_BANKS])
				bank_open <= 4'h0;
			else
				bank_open[ba_q] <= 1'b0; // [RL3]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			blc_q               <= `SDM_BL_RST;
			bt_q                <= 1'b0;
			read_latency_cycles <= `SDM_LAT_RST;
		end else if (hit && cmd_q == sdm_pkg::CMD_LMR) begin
			blc_q               <= a_q[`SDM_MR_BL_LSB +: 3];
			bt_q                <= a_q[`SDM_MR_BT_BIT];
			read_latency_cycles <= a_q[`SDM_MR_LAT_LSB +: 3]; // [RL8]
		end
	end

	// burst sequencer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bst_on_q   <= 1'b0;
			bst_wr_q   <= 1'b0;
			bst_bank_q <= 2'h0;
			bst_base_q <= '0;
			bst_idx_q  <= 4'h0;
			bst_len_q  <= 4'h1;
		end else if (new_rw) begin
			bst_on_q   <= sdm_pkg::bl_of(blc_q) > 4'h1; // [RL7]
			bst_wr_q   <= cmd_q == sdm_pkg::CMD_WR;
			bst_bank_q <= ba_q;
			bst_base_q <= a_q[COL_W-1:0];
			bst_idx_q  <= 4'h1;
			bst_len_q  <= sdm_pkg::bl_of(blc_q);
		end else if (hit && (cmd_q == sdm_pkg::CMD_BST || (cmd_q == sdm_pkg::CMD_PRE &&
			(a_q[`SDM_ALL_BANKS] || ba_q == bst_bank_q)))) begin
			bst_on_q <= 1'b0;
		end else if (bst_on_q) begin
			bst_idx_q <= bst_idx_q + 4'h1;
			if (bst_idx_q == bst_len_q - 4'h1)
				bst_on_q <= 1'b0;
		end
	end

	// storage and read data path
	always_ff @(posedge mclk) begin
		if (beat_on && beat_wr) begin
			for (int i = 0; i < 8; i++)
				if (!dqm_q[i])
					mem[beat_idx][8*i +: 8] <= dq_q[8*i +: 8]; // [RL15] [RL5]
		end
		rp_d_q[0] <= mem[beat_idx]; // [RL5]
		rp_d_q[1] <= rp_d_q[0];
	end

	assign out_v = (read_latency_cycles == 3'h2) ? rp_v_q[0] : rp_v_q[1];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rp_v_q    <= 2'h0;
			mask_p1_q <= 8'hFF;
			dq_o_q    <= 64'h0;
			oe_q      <= 8'h00;
		end else begin
			rp_v_q    <= {rp_v_q[0], beat_on & ~beat_wr};
			mask_p1_q <= dqm_q;
			dq_o_q    <= (read_latency_cycles == 3'h2) ? rp_d_q[0] : rp_d_q[1]; // [RL8]
			oe_q      <= {8{out_v}} & ~mask_p1_q; // [RL15]
		end
	end

	assign lnk.dq_d_o  = dq_o_q;
	assign lnk.dq_d_oe = oe_q;
endmodule : sdm_dev_end

//--- sdm_host_end.sv
// controller end: init, refresh, closed-row access sequencing, read buffering
// Contract
// [RL1] all link inputs taken on rising edge
// [RL2] new column address accepted every cycle
// [RL3] four banks with independent row state
// [RL4] 4096 refreshes in every 64 ms
// [RL5] every data beat is 64 bits
// [RL6] open row with ACTIVE before access
// [RL7] bursts run programmed length in order
// [RL8] read data after programmed latency
// [RL9] row open 50 ns to 16K ns
// [RL10] ACTIVE or refresh to ACTIVE spacing
// [RL11] three cycles ACTIVE to column access
// [RL12] three cycles precharge to next ACTIVE
// [RL13] two cycles between ACTIVE, different banks
// [RL14] two cycles after loading mode register
// [RL15] byte masks gate write and read lanes
// [RL16] chip select gates commands; bank selected
`timescale 1ns/1ps
`include "sdm_params.svh"
module sdm_host_end #(
	parameter int       COL_W      = 8,
	parameter int       DEPTH      = 16,
	parameter int       REF_CYC    = `SDM_REF_CYC,
	parameter bit [2:0] BURST_CODE = 3'h2,
	parameter bit       BURST_IL   = 1'b0,
	parameter bit [2:0] READ_LAT   = 3'h3
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	sdm_link_if.host              lnk,
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire logic             req_write,
	input  wire logic [1:0]       req_bank,
	input  wire logic [11:0]      req_row,
	input  wire logic [COL_W-1:0] req_col,
	input  wire logic [63:0]      req_wdata,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [63:0]           rd_data,
	output logic                  init_done
);
	localparam logic [3:0] BL = sdm_pkg::bl_of(BURST_CODE);
	localparam logic [11:0] MODE_WORD = (12'(READ_LAT) << `SDM_MR_LAT_LSB) |
		(12'(BURST_IL) << `SDM_MR_BT_BIT) | (12'(BURST_CODE) << `SDM_MR_BL_LSB);
	localparam int TAP = int'(READ_LAT) + 1;

	sdm_pkg::sdm_state_e st_q;
	sdm_pkg::sdm_state_e nxt_q;
	sdm_pkg::sdm_cmd_e   cmd_q;
	logic [7:0]          wait_q;
	logic [7:0]          rc_q;
	logic [3:0]          beats_q;
	logic [1:0]          refs_q;
	logic                wr_q;
	logic [COL_W-1:0]    col_q;
	logic [63:0]         wdata_q;
	logic [1:0]          bank_q;
	logic [11:0]         addr_q;
	logic [7:0]          mask_q;
	logic [63:0]         dout_q;
	logic                oe_q;
	logic [63:0]         dq_in_q;
	logic [4:0]          dl_q;
	logic [15:0]         ref_cnt_q;
	logic                ref_due_q;
	logic                ref_take;
	logic                rd_busy;
	logic                can_take;
	logic                fifo_in_rdy;
	logic [$clog2(DEPTH)+1:0] fifo_lvl;

	assign lnk.chip_select_low_rank_n = 1'b0; // [RL16]
	assign lnk.cmd         = cmd_q;
	assign lnk.bank_select = bank_q;
	assign lnk.addr        = addr_q;
	assign lnk.byte_mask   = mask_q;
	assign lnk.dq_h_o      = dout_q;
	assign lnk.dq_h_oe     = oe_q;

	assign rd_busy  = (beats_q != 4'h0) | (dl_q != 5'h00);
	assign can_take = ~ref_due_q & (rc_q == 8'h00) & ~rd_busy & fifo_in_rdy &
		(32'(fifo_lvl) + 32'(BL) <= DEPTH);
	assign ref_take = (st_q == sdm_pkg::S_IDLE) & ref_due_q & (rc_q == 8'h00) &
		~(req_ready & req_valid);

	// refresh interval timer; expiry beats a same-cycle clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ref_cnt_q <= 16'h0000;
			ref_due_q <= 1'b0;
		end else begin
			ref_cnt_q <= (ref_cnt_q == 16'(REF_CYC - 1)) ? 16'h0000 : ref_cnt_q + 16'h1;
			if (ref_cnt_q == 16'(REF_CYC - 1))
				ref_due_q <= 1'b1; // [RL4]
			else if (ref_take)
				ref_due_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q      <= sdm_pkg::S_INIT_PRE;
			nxt_q     <= sdm_pkg::S_IDLE;
			cmd_q     <= sdm_pkg::CMD_NOP;
			wait_q    <= 8'h00;
			rc_q      <= 8'h00;
			beats_q   <= 4'h0;
			refs_q    <= 2'(`SDM_INIT_REFS);
			wr_q      <= 1'b0;
			col_q     <= '0;
			wdata_q   <= 64'h0;
			bank_q    <= 2'h0;
			addr_q    <= 12'h000;
			mask_q    <= 8'h00;
			dout_q    <= 64'h0;
			oe_q      <= 1'b0;
			req_ready <= 1'b0;
			init_done <= 1'b0;
		end else begin
			cmd_q <= sdm_pkg::CMD_NOP;
			if (rc_q != 8'h00)
				rc_q <= rc_q - 8'h01;
			if (beats_q != 4'h0)
				beats_q <= beats_q - 4'h1;
			// trailing write beats carry full masks so only the first word lands
			oe_q   <= wr_q & (beats_q > 4'h1);
			mask_q <= {8{wr_q & (beats_q > 4'h1)}}; // [RL15]
			case (st_q)
				sdm_pkg::S_INIT_PRE: begin
					cmd_q  <= sdm_pkg::CMD_PRE;
					addr_q <= 12'h001 << `SDM_ALL_BANKS;
					wait_q <= 8'(`SDM_RP_CYC - 1); // [RL12]
					nxt_q  <= sdm_pkg::S_INIT_REF;
					st_q   <= sdm_pkg::S_WAIT;
				end
				sdm_pkg::S_INIT_REF: begin
					cmd_q  <= sdm_pkg::CMD_REF;
					refs_q <= refs_q - 2'h1;
					rc_q   <= 8'(`SDM_RC_CYC - 1);
					wait_q <= 8'(`SDM_RC_CYC - 1); // [RL10]
					nxt_q  <= (refs_q == 2'h1) ? sdm_pkg::S_MODE : sdm_pkg::S_INIT_REF;
					st_q   <= sdm_pkg::S_WAIT;
				end
				sdm_pkg::S_MODE: begin
					cmd_q     <= sdm_pkg::CMD_LMR;
					addr_q    <= MODE_WORD; // [RL7] [RL8]
					wait_q    <= 8'(`SDM_MRD_CYC - 1); // [RL14]
					nxt_q     <= sdm_pkg::S_IDLE;
					st_q      <= sdm_pkg::S_WAIT;
					init_done <= 1'b1;
				end
				sdm_pkg::S_IDLE: begin
					if (req_ready && req_valid) begin
						// rc_q is zero here, which also covers the bank-to-bank gap
						req_ready <= 1'b0;
						wr_q      <= req_write;
						col_q     <= req_col;
						wdata_q   <= req_wdata;
						cmd_q     <= sdm_pkg::CMD_ACT; // [RL6] [RL10] [RL13]
						bank_q    <= req_bank;
						addr_q    <= req_row;
						rc_q      <= 8'(`SDM_RC_CYC - 1);
						wait_q    <= 8'(`SDM_RCD_CYC - 1); // [RL11]
						nxt_q     <= sdm_pkg::S_RW;
						st_q      <= sdm_pkg::S_WAIT;
					end else if (ref_take) begin
						req_ready <= 1'b0;
						cmd_q     <= sdm_pkg::CMD_REF; // [RL4]
						rc_q      <= 8'(`SDM_RC_CYC - 1);
						wait_q    <= 8'(`SDM_RC_CYC - 1); // [RL10]
						nxt_q     <= sdm_pkg::S_IDLE;
						st_q      <= sdm_pkg::S_WAIT;
					end else begin
						req_ready <= can_take;
					end
				end
				sdm_pkg::S_RW: begin
					cmd_q   <= wr_q ? sdm_pkg::CMD_WR : sdm_pkg::CMD_RD; // [RL6]
					addr_q  <= 12'(col_q);
					beats_q <= BL; // [RL7]
					if (wr_q) begin
						oe_q   <= 1'b1;
						dout_q <= wdata_q; // [RL5]
						mask_q <= 8'h00;
					end
					// last beat plus write recovery before closing the row
					wait_q <= 8'(BL) + 8'(`SDM_RDL_CYC - 2);
					nxt_q  <= sdm_pkg::S_PRE;
					st_q   <= sdm_pkg::S_WAIT;
				end
				sdm_pkg::S_PRE: begin
					cmd_q  <= sdm_pkg::CMD_PRE; // [RL9]
					addr_q <= 12'h000;
					wait_q <= 8'(`SDM_RP_CYC - 1); // [RL12]
					nxt_q  <= sdm_pkg::S_IDLE;
					st_q   <= sdm_pkg::S_WAIT;
				end
				sdm_pkg::S_WAIT: begin
					wait_q <= wait_q - 8'h01;
					if (wait_q <= 8'h01)
						st_q <= nxt_q;
				end
				default: st_q <= sdm_pkg::S_INIT_PRE;
			endcase
		end
	end

	// data lines taken on the rising edge; read beats tracked to their arrival
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dq_in_q <= 64'h0;
			dl_q    <= 5'h00;
		end else begin
			dq_in_q <= lnk.dq; // [RL1]
			dl_q    <= {dl_q[3:0], (beats_q != 4'h0) & ~wr_q}; // [RL8]
		end
	end

	sdm_fifo #(
		.WIDTH (64),
		.DEPTH (DEPTH)
	) u_rd_fifo (
		.mclk      (mclk),
		.nrst      (nrst),
		.in_valid  (dl_q[TAP]),
		.in_ready  (fifo_in_rdy),
		.in_data   (dq_in_q),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data),
		.level     (fifo_lvl)
	);
endmodule : sdm_host_end

//--- sdm_link_assertions.sv
// link checks: command spacing, read latency, burst framing, refresh rate
`timescale 1ns/1ps
`include "sdm_params.svh"
module sdm_link_assertions #(
	parameter int REF_CYC = `SDM_REF_CYC
) (
	input wire logic              mclk,
	input wire logic              nrst,
	input wire logic              chip_select_low_rank_n,
	input wire sdm_pkg::sdm_cmd_e cmd,
	input wire logic [1:0]        bank_select,
	input wire logic [11:0]       addr,
	input wire logic [7:0]        byte_mask,
	input wire logic [63:0]       dq_h_o,
	input wire logic              dq_h_oe,
	input wire logic [63:0]       dq_d_o,
	input wire logic [7:0]        dq_d_oe,
	input wire logic [63:0]       dq
);
	logic        is_act;
	logic        is_rd;
	logic        is_wr;
	logic        is_pre;
	logic        is_lmr;
	logic        is_ref;
	logic [8:0]  since_act_q;
	logic [10:0] since_ref_q;

	assign is_act = cmd == sdm_pkg::CMD_ACT;
	assign is_rd  = cmd == sdm_pkg::CMD_RD;
	assign is_wr  = cmd == sdm_pkg::CMD_WR;
	assign is_pre = cmd == sdm_pkg::CMD_PRE;
	assign is_lmr = cmd == sdm_pkg::CMD_LMR;
	assign is_ref = cmd == sdm_pkg::CMD_REF;

	// cycles since the last activate or refresh, saturating
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			since_act_q <= 9'h1FF;
		end else if (is_act || is_ref) begin
			since_act_q <= 9'h001;
		end else if (since_act_q != 9'h1FF) begin
			since_act_q <= since_act_q + 9'h001;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			since_ref_q <= 11'h000;
		end else if (is_ref) begin
			since_ref_q <= 11'h000;
		end else if (since_ref_q != 11'h7FF) begin
			since_ref_q <= since_ref_q + 11'h001;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	act_to_access_a: assert property (is_act |=> !(is_rd || is_wr) [*2])
		else $error("column access too soon after activate");
	pre_to_act_a: assert property (is_pre |=> !is_act [*2])
		else $error("activate too soon after precharge");
	mode_gap_a: assert property (is_lmr |=> cmd == sdm_pkg::CMD_NOP)
		else $error("command too soon after mode load");
	act_cycle_a: assert property (is_act |-> since_act_q >= `SDM_RC_CYC)
		else $error("activate inside row cycle time");
	bank_gap_a: assert property (is_act |=> !is_act)
		else $error("activates one cycle apart");
	read_latency_a: assert property (is_rd |-> ##3 dq_d_oe == 8'h00 ##1 dq_d_oe == 8'hFF)
		else $error("read data not at programmed latency");
	read_burst_a: assert property (is_rd |-> ##4 dq_d_oe == 8'hFF [*4] ##1 dq_d_oe == 8'h00)
		else $error("read burst length wrong");
	write_lanes_a: assert property (is_wr |-> dq_h_oe && byte_mask == 8'h00 ##1
		(dq_h_oe && byte_mask == 8'hFF) [*3] ##1 !dq_h_oe)
		else $error("write burst lanes not masked");
	write_close_a: assert property (is_wr |-> ##5 is_pre)
		else $error("row not closed after write");
	bus_turn_a: assert property (!(dq_h_oe && dq_d_oe != 8'h00))
		else $error("both ends drive data");
	refresh_rate_a: assert property (since_ref_q < 11'(2 * REF_CYC))
		else $error("refresh overdue");
endmodule : sdm_link_assertions

//--- sdram_module_command_timing_tb_top.sv
// end-to-end bench: host and module ends on one link, a lone module on a second
`timescale 1ns/1ps
module sdram_module_command_timing_tb_top;
	localparam int REF_CYC = 40;
	logic        mclk;
	logic        nrst;
	logic        req_valid;
	logic        req_ready;
	logic        req_write;
	logic [1:0]  req_bank;
	logic [11:0] req_row;
	logic [7:0]  req_col;
	logic [63:0] req_wdata;
	logic        rd_valid;
	logic        rd_ready;
	logic        hold_rd;
	logic [63:0] rd_data;
	logic        init_done;
	logic [3:0]  bank_open;
	logic [3:0]  bank_open_b;
	logic [2:0]  rd_lat;
	logic [2:0]  rd_lat_b;
	int          err_total;
	int          n_compared;
	int          cyc;
	logic [63:0] mem [logic [11:0]];
	logic [63:0] exp_q [$];

	sdm_link_if lnk ();
	sdm_link_if lnk_b ();

	sdm_host_end #(.REF_CYC(REF_CYC)) i_sdm_host_end (
		.mclk(mclk), .nrst(nrst), .lnk(lnk), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
		.req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.init_done(init_done));
	sdm_dev_end i_sdm_dev_end (.mclk(mclk), .nrst(nrst), .lnk(lnk), .bank_open(bank_open),
		.read_latency_cycles(rd_lat));
	// lone module driven by the bench for deselect, closed-bank and mask cases
	sdm_dev_end i_sdm_dev_end_b (.mclk(mclk), .nrst(nrst), .lnk(lnk_b),
		.bank_open(bank_open_b), .read_latency_cycles(rd_lat_b));
	sdm_link_assertions #(.REF_CYC(REF_CYC)) i_sdm_link_assertions (
		.mclk(mclk), .nrst(nrst), .chip_select_low_rank_n(lnk.chip_select_low_rank_n),
		.cmd(lnk.cmd), .bank_select(lnk.bank_select), .addr(lnk.addr),
		.byte_mask(lnk.byte_mask), .dq_h_o(lnk.dq_h_o), .dq_h_oe(lnk.dq_h_oe),
		.dq_d_o(lnk.dq_d_o), .dq_d_oe(lnk.dq_d_oe), .dq(lnk.dq));

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
		n_compared++;
		if (seen !== expv) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// one host request; model updated one edge after the take
	task automatic access(input logic wr, input logic [1:0] b, input logic [11:0] r,
		input logic [7:0] c, input logic [63:0] d);
		req_write = wr;
		req_bank = b;
		req_row = r;
		req_col = c;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		// let an edge pass so a following request never re-raises valid in this step
		@(posedge mclk);
		#1;
		if (wr) begin
			mem[{b, r[1:0], c}] = d;
		end else begin
			for (int i = 0; i < 4; i++) begin
				exp_q.push_back(mem[{b, r[1:0], c[7:2], 2'(c[1:0] + i[1:0])}]);
			end
		end
	endtask : access

	task automatic link_cmd(input logic cs_n, input sdm_pkg::sdm_cmd_e c, input logic [1:0] b,
		input logic [11:0] a);
		lnk_b.chip_select_low_rank_n = cs_n;
		lnk_b.cmd = c;
		lnk_b.bank_select = b;
		lnk_b.addr = a;
		@(posedge mclk);
		#1;
	endtask : link_cmd

	// idle the lone link for n cycles; stale address is scrambled
	task automatic step(input int n);
		lnk_b.chip_select_low_rank_n = 1'b0;
		lnk_b.cmd = sdm_pkg::CMD_NOP;
		lnk_b.addr = ~lnk_b.addr;
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task automatic drain;
		while (exp_q.size() != 0) begin
			@(posedge mclk);
		end
		repeat (3) @(posedge mclk);
		#1;
		check("read data left", rd_valid, 1'b0);
	endtask : drain

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			complete_run();
		end
	end

	always @(posedge mclk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("spare read word", 1'b1, 1'b0);
			end else begin
				check("read word", rd_data, exp_q.pop_front());
			end
		end
		#1 rd_ready = !hold_rd && ($urandom_range(3) != 0);
	end

	initial begin
		logic [1:0]  bb [8];
		logic [11:0] rr [8];
		logic [7:0]  cc [8];
		nrst = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_bank = 2'h0;
		req_row = 12'h000;
		req_col = 8'h00;
		req_wdata = 64'h0;
		rd_ready = 1'b0;
		hold_rd = 1'b0;
		lnk_b.byte_mask = 8'h00;
		lnk_b.dq_h_o = 64'h0;
		lnk_b.dq_h_oe = 1'b0;
		lnk_b.addr = 12'h000;
		lnk_b.bank_select = 2'h0;
		void'($urandom(32'h2C1BC81A));
		step(5);
		check("reset state", {lnk.cmd, lnk.dq_d_oe, bank_open, rd_lat, req_ready, init_done},
			{3'h7, 8'h00, 4'h0, 3'h3, 2'b00});
		nrst = 1'b1;
		while (init_done !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		// mode load lands in the module two edges after the host shows it
		repeat (2) @(posedge mclk);
		#1;
		check("latency after init", rd_lat, 3'h3);
		$display("test reset_init done");
		for (int n = 0; n < 8; n++) begin
			bb[n] = n[1:0];
			rr[n] = 12'($urandom);
			cc[n] = 8'($urandom) & 8'hFC;
			for (int i = 0; i < 4; i++) begin
				access(1'b1, bb[n], rr[n], cc[n] + 8'(i), {$urandom, $urandom});
			end
		end
		$display("test write_blocks done");
		for (int n = 0; n < 8; n++) begin
			access(1'b0, bb[n], rr[n], cc[n] + 8'($urandom_range(3)), 64'h0);
		end
		drain();
		$display("test wrapped_reads done");
		hold_rd = 1'b1;
		for (int n = 0; n < 4; n++) begin
			access(1'b0, bb[n], rr[n], cc[n], 64'h0);
		end
		repeat (40) @(posedge mclk);
		#1;
		check("fifo full refusal", {req_ready, rd_valid}, 2'b01);
		hold_rd = 1'b0;
		drain();
		$display("test fifo_fill done");
		link_cmd(1'b1, sdm_pkg::CMD_ACT, 2'h2, 12'h005);
		step(3);
		check("deselected activate", bank_open_b, 4'h0);
		link_cmd(1'b0, sdm_pkg::CMD_ACT, 2'h2, 12'h005);
		step(3);
		check("bank opened", bank_open_b, 4'h4);
		link_cmd(1'b0, sdm_pkg::CMD_RD, 2'h1, 12'h000);
		for (int i = 0; i < 6; i++) begin
			step(1);
			check("closed bank read", lnk_b.dq_d_oe, 8'h00);
		end
		link_cmd(1'b0, sdm_pkg::CMD_PRE, 2'h0, 12'h400);
		step(3);
		check("all banks closed", bank_open_b, 4'h0);
		link_cmd(1'b0, sdm_pkg::CMD_LMR, 2'h0, 12'h022);
		step(2);
		check("latency programmed", rd_lat_b, 3'h2);
		link_cmd(1'b0, sdm_pkg::CMD_ACT, 2'h0, 12'h000);
		step(2);
		lnk_b.byte_mask = 8'h0F;
		link_cmd(1'b0, sdm_pkg::CMD_RD, 2'h0, 12'h000);
		link_cmd(1'b0, sdm_pkg::CMD_RD, 2'h0, 12'h004);
		for (int i = 0; i < 7; i++) begin
			check("masked back-to-back read", lnk_b.dq_d_oe,
				(i >= 1 && i <= 5) ? 8'hF0 : 8'h00);
			step(1);
		end
		lnk_b.byte_mask = 8'h00;
		$display("test lone_module done");
		complete_run();
	end
endmodule : sdram_module_command_timing_tb_top
